//--- dv/abc_ctrl_properties.sv
// abc_ctrl_properties: port-level checks for the brightness control block
// assumes one sys_clk domain and the asynchronous active-low arst_n
`timescale 1ns/100ps
module abc_ctrl_properties (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [3:0] sensorLevel,
  input wire logic       boostIn,
  input wire logic [4:0] engineEvent,
  input wire logic       sensorSwitch,
  input wire logic       keypadLed1,
  input wire logic       keypadLed2,
  input wire logic [6:0] mainCurrent,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // device moves its sda drive
  sequence s_sdaMove;
    $changed(sdaOe);
  endsequence
  // interrupt line goes up
  sequence s_irqUp;
    $rose(irq);
  endsequence
  AST_RESET_QUIET: assert property ($rose(arst_n) |-> !sensorSwitch && mainCurrent == 7'h00)
    else $error("sensor or current active after reset");
  AST_RESET_LEDS: assert property ($rose(arst_n) |-> !keypadLed1 && !keypadLed2 ##1 !irq)
    else $error("led or irq active after reset");
  AST_NO_EARLY_ACK: assert property ($rose(arst_n) |-> (!sdaOe)[*4])
    else $error("sda driven right after reset");
  AST_OPEN_DRAIN: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("sda driven high");
  AST_SDA_SCL_LOW: assert property (s_sdaMove |-> !sclIn)
    else $error("sda moved while scl high");
  AST_SDA_HOLD: assert property (s_sdaMove |=> ($stable(sdaOe))[*4])
    else $error("sda drive too short");
  AST_IRQ_HOLD: assert property (s_irqUp |=> irq[*2])
    else $error("irq dropped without clear");
  AST_IRQ_FALL_SCL_LOW: assert property ($fell(irq) |-> !sclIn)
    else $error("irq fell outside a host write");
endmodule : abc_ctrl_properties

bind abc_brightness_ctrl abc_ctrl_properties i_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .sensorLevel(sensorLevel), .boostIn(boostIn), .engineEvent(engineEvent),
  .sensorSwitch(sensorSwitch), .keypadLed1(keypadLed1), .keypadLed2(keypadLed2),
  .mainCurrent(mainCurrent), .irq(irq));

//--- dv/abc_i2c_host.sv
// abc_i2c_host: bus master model standing in for the host processor
// assumes sda has a pull-up and the device only pulls it low
`timescale 1ns/100ps
module abc_i2c_host (
  input  wire logic       sys_clk,
  input  wire logic       sdaOe,
  output logic            sclLine,
  output logic            sdaLine,
  output logic            rdDone,
  output logic [7:0]      rdData,
  output int              nackCount
);
  import abc_pkg::*;
  logic hostLow;
  // wired-and, a released line floats high
  assign sdaLine = !(hostLow || sdaOe);
  // bus idle at time zero
  initial begin
    sclLine   = 1'b1;
    hostLow   = 1'b0;
    rdDone    = 1'b0;
    rdData    = 8'h00;
    nackCount = 0;
  end
  // one scl phase, twice the synchroniser delay
  task automatic phase();
    repeat (8) @(negedge sys_clk);
  endtask : phase
  // sda moves only inside the low phase, never beside an scl edge
  task automatic bitIo(input logic b, output logic s);
    repeat (2) @(negedge sys_clk);
    hostLow = !b;
    phase();
    sclLine = 1'b1;
    phase();
    s       = sdaLine;
    sclLine = 1'b0;
  endtask : bitIo
  // byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic ackBit, output logic [7:0] got,
                      output logic s);
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], got[i]);
    end
    bitIo(ackBit, s);
  endtask : xfer
  // start or repeated start
  task automatic start();
    repeat (2) @(negedge sys_clk);
    hostLow = 1'b0;
    phase();
    sclLine = 1'b1;
    phase();
    hostLow = 1'b1;
    phase();
    sclLine = 1'b0;
  endtask : start
  task automatic stop();
    repeat (2) @(negedge sys_clk);
    hostLow = 1'b1;
    phase();
    sclLine = 1'b1;
    phase();
    hostLow = 1'b0;
    phase();
  endtask : stop
  // send a byte and count a missing acknowledge
  task automatic put(input logic [7:0] b);
    logic [7:0] g;
    logic       s;
    xfer(b, 1'b1, g, s);
    if (s) begin
      nackCount++;
    end
  endtask : put
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    start();
    put({DEV_ADDR, 1'b0});
    put(a);
    put(d);
    stop();
  endtask : writeReg
  // address-only frame, used for a foreign slave address
  task automatic probe(input logic [6:0] a);
    start();
    put({a, 1'b0});
    stop();
  endtask : probe
  task automatic readReg(input logic [7:0] a);
    logic [7:0] g;
    logic       s;
    start();
    put({DEV_ADDR, 1'b0});
    put(a);
    start();
    put({DEV_ADDR, 1'b1});
    xfer(8'hFF, 1'b1, g, s);
    stop();
    rdData = g;
    rdDone = 1'b1;
    @(negedge sys_clk);
    rdDone = 1'b0;
  endtask : readReg
endmodule : abc_i2c_host

//--- dv/ambient_brightness_irq_ctrl_tb.sv
// ambient_brightness_irq_ctrl_tb: self-checking bench for abc_brightness_ctrl
// assumes the host model owns the bus and shortened sensor timing
`timescale 1ns/100ps
module ambient_brightness_irq_ctrl_tb;
  import abc_pkg::*;
  logic       sys_clk, arst_n, sclLine, sdaLine, sdaOut, sdaOe, boostIn;
  logic       sensorSwitch, keypadLed1, keypadLed2, irq, rdDone;
  logic [3:0] sensorLevel, lvl, thr;
  logic [4:0] engineEvent;
  logic [6:0] mainCurrent;
  logic [7:0] rdData;
  logic [7:0] expQ[$];
  int         nackCount, onCnt, seed;
  int         mismatches = 0;
  int         totalChecks = 0;
  int         cycles = 0;

  abc_brightness_ctrl #(.BASE_PERIOD(64), .FAST_PERIOD(40), .SAMPLE_GAP(4)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sensorLevel(sensorLevel), .boostIn(boostIn), .engineEvent(engineEvent),
    .sensorSwitch(sensorSwitch), .keypadLed1(keypadLed1), .keypadLed2(keypadLed2),
    .mainCurrent(mainCurrent), .irq(irq));
  abc_i2c_host i_host (.sys_clk(sys_clk), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine),
    .rdDone(rdDone), .rdData(rdData), .nackCount(nackCount));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : endSim
  // note the expectation, then read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_host.readReg(a);
  endtask : rd
  // one-cycle engine pulse, flag and irq settle after
  task automatic ev(input logic [4:0] v);
    engineEvent = v;
    @(negedge sys_clk);
    engineEvent = 5'h00;
    repeat (3) @(negedge sys_clk);
  endtask : ev
  task automatic clr(input logic [7:0] m);
    i_host.writeReg(OFS_IRQ_MASK, 8'h80 | m);
    i_host.writeReg(OFS_IRQ_MASK, m);
  endtask : clr
  // compare each finished read with the oldest note
  always @(posedge sys_clk) begin
    if (rdDone === 1'b1) begin
      if (expQ.size() == 0) begin
        mismatches++;
        $display("Error at %0t: got %h expected %h", $time, rdData, 8'h00);
      end else begin
        check(rdData, expQ.pop_front());
      end
    end
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, cycles, 0);
      endSim();
    end
  end
  // main sequence
  initial begin
    seed = 23;
    arst_n = 1'b0;
    boostIn = 1'b0;
    sensorLevel = 4'h0;
    engineEvent = 5'h00;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    i_host.writeReg(OFS_KEY_THRESH, 8'hFF);
    rd(OFS_KEY_THRESH, 8'h00);
    rd(8'h55, 8'h00);
    i_host.probe(DEV_ADDR ^ 7'h01);
    check(8'(nackCount), 8'h01);
    clr(8'h00);
    rd(OFS_IRQ_DETECT, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      ev(5'(1 << i));
      check({7'h00, irq}, 8'h01);
      rd(OFS_IRQ_DETECT, 8'(2 << i));
      clr(8'h00);
      check({7'h00, irq}, 8'h00);
    end
    i_host.writeReg(OFS_IRQ_MASK, 8'h3F);
    ev(5'h1F);
    check({7'h00, irq}, 8'h00);
    rd(OFS_IRQ_DETECT, 8'h3E);
    i_host.writeReg(OFS_IRQ_MASK, 8'h00);
    check({7'h00, irq}, 8'h01);
    i_host.writeReg(OFS_IRQ_MASK, 8'h80);
    ev(5'h04);
    rd(OFS_IRQ_DETECT, 8'h00);
    i_host.writeReg(OFS_IRQ_MASK, 8'h00);
    $display("test interrupts done");
    lvl = 4'd2 + 4'(($random(seed) & 32'h7FFF_FFFF) % 13);
    thr = lvl - 4'd1;
    sensorLevel = lvl;
    boostIn = 1'b1;
    i_host.writeReg(OFS_KEY_THRESH, {lvl, thr});
    i_host.writeReg(OFS_KEY_AUTO, 8'h03);
    i_host.writeReg(OFS_CURRENT_LVL0, 8'h11);
    i_host.writeReg(OFS_CURRENT_LVL0 + {4'h0, lvl}, {4'h2, lvl});
    i_host.writeReg(OFS_CURRENT_LVL0 + {4'h0, thr}, {4'h3, thr});
    i_host.writeReg(OFS_SENSOR_CTRL, 8'h7F);
    repeat (200) @(negedge sys_clk);
    check({1'b0, mainCurrent}, {4'h2, lvl});
    check({6'h00, keypadLed2, keypadLed1}, 8'h02);
    check({7'h00, sensorSwitch}, 8'h01);
    rd(OFS_STATUS, {lvl, 4'h1});
    clr(8'h00);
    sensorLevel = thr;
    repeat (200) @(negedge sys_clk);
    check({6'h00, keypadLed2, keypadLed1}, 8'h03);
    check({1'b0, mainCurrent}, {4'h3, thr});
    check({7'h00, irq}, 8'h01);
    rd(OFS_STATUS, {thr, 4'h3});
    rd(OFS_IRQ_DETECT, 8'h01);
    $display("test sensor done");
    i_host.writeReg(OFS_SENSOR_CTRL, 8'hDF);
    repeat (20) @(negedge sys_clk);
    check({1'b0, mainCurrent}, 8'h11);
    check({7'h00, sensorSwitch}, 8'h00);
    i_host.writeReg(OFS_SENSOR_CTRL, 8'h49);
    onCnt = 0;
    repeat (640) begin
      @(negedge sys_clk);
      onCnt += sensorSwitch;
    end
    check(8'(onCnt > 0 && onCnt < 320), 8'h01);
    boostIn = 1'b0;
    i_host.writeReg(OFS_SENSOR_CTRL, 8'h00);
    repeat (20) @(negedge sys_clk);
    check({7'h00, sensorSwitch}, 8'h00);
    rd(OFS_STATUS, {thr, 4'h2});
    $display("test modes done");
    endSim();
  end
endmodule : ambient_brightness_irq_ctrl_tb

//--- pkg/abc_pkg.sv
// abc_pkg: constants and types for the ambient brightness control block
// assumes a 200 MHz system clock and byte-wide registers behind an i2c slave
package abc_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned BASE_PERIOD_US   = 131072;  // period code 0, 131.072 ms
  localparam int unsigned FAST_PERIOD_US   = 20000;   // period code 7, 20 ms
  localparam int unsigned SAMPLE_GAP_NS    = 1000;    // sensor settle / sample spacing
  localparam int unsigned BASE_PERIOD_CYC  = BASE_PERIOD_US * CLK_MHZ;
  localparam int unsigned FAST_PERIOD_CYC  = FAST_PERIOD_US * CLK_MHZ;
  localparam int unsigned SAMPLE_GAP_CYC   = (SAMPLE_GAP_NS * CLK_MHZ + 999) / 1000;

  // register offsets
  localparam logic [7:0] OFS_KEY_THRESH    = 8'h2B;
  localparam logic [7:0] OFS_SENSOR_CTRL   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h2D;
  localparam logic [7:0] OFS_IRQ_DETECT    = 8'h2E;
  localparam logic [7:0] OFS_STATUS        = 8'h2F;
  localparam logic [7:0] OFS_CURRENT_LVL0  = 8'h30;
  localparam logic [7:0] OFS_CURRENT_LAST  = 8'h3F;
  localparam logic [7:0] OFS_KEY_AUTO      = 8'h40;

  // reset values
  localparam logic [7:0] RST_KEY_THRESH    = 8'h00;
  localparam logic [7:0] RST_SENSOR_CTRL   = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK      = 8'h00;
  localparam logic [6:0] RST_CURRENT       = 7'h00;
  localparam logic [1:0] RST_KEY_AUTO      = 2'h0;

  // field positions and codes
  localparam int unsigned IRQ_CLEAR_BIT    = 7;
  localparam int unsigned NUM_IRQ          = 6;
  localparam logic [3:0]  THRESH_INHIBIT   = 4'hF;
  localparam logic [2:0]  PERIOD_FAST_CODE = 3'h7;
  localparam int unsigned NUM_LEVELS       = 16;

  // i2c slave address, value arbitrary
  localparam logic [6:0]  DEV_ADDR         = 7'h3A;

  // sensor sampling control layout
  typedef struct packed {
    logic       switchInvert;   // D7
    logic       sensorPower;    // D6
    logic       backlightAuto;  // D5
    logic [1:0] sampleCount;    // D4..D3
    logic [2:0] samplePeriod;   // D2..D0
  } abc_sensor_ctrl_s;

  // key threshold layout
  typedef struct packed {
    logic [3:0] second;         // D7..D4
    logic [3:0] first;          // D3..D0
  } abc_key_thresh_s;

  typedef enum logic [3:0] {
    I2C_IDLE    = 4'b0000,
    I2C_ADDR    = 4'b0001,
    I2C_ACK_A   = 4'b0010,
    I2C_REG     = 4'b0011,
    I2C_ACK_REG = 4'b0100,
    I2C_WDATA   = 4'b0101,
    I2C_ACK_W   = 4'b0110,
    I2C_RDATA   = 4'b0111,
    I2C_ACK_R   = 4'b1000
  } abc_i2c_state_e;

  typedef enum logic [1:0] {
    SNS_OFF     = 2'b00,
    SNS_WAIT    = 2'b01,
    SNS_MEAS    = 2'b10
  } abc_sensor_state_e;

endpackage : abc_pkg

//--- verilog/abc_brightness_ctrl.sv
// abc_brightness_ctrl: ambient brightness control, key led switching,
// backlight current selection and interrupt detection, behind an i2c slave.
// assumes scl/sda/level/boost come from pins; event pulses are same-clock.
//
// Functional notes
// - First key threshold, 4 bits, codes 0-14 pick level 1-15, all-ones inhibited.
// - Second key threshold sits in bits 7..4 with identical coding.
// - Key led turns on when auto enabled and level falls to the threshold.
// - Status bits 7..4 report ambient level, code 0 meaning level 1.
// - Period field: codes 0-6 double from 131.072 ms, code 7 is 20 ms.
// - Sensor runs continuously at 20 ms, otherwise powered once per period.
// - Samples per measurement equal count field plus one, one to four.
// - Backlight uses fixed current when auto bit is 0, level table when 1.
// - Sensor powered only while power bit is 1; off after reset.
// - Sensor switch polarity normal when bit 7 is 0, inverted when 1.
// - Six mask bits, one per source; a 1 masks; all clear at reset.
// - Clear bit 1 clears pending flags; host returns it to 0 to re-enable.
// - Six read-only detect flags: key detect, white fade, two fades, two gradations.
// - Each unmasked detect flag reading 1 raises the interrupt.
// - Status bit 0 shows boost stepping up, 0 in pass-through.
// - Status bit 1 is 1 while brightness at or below first key threshold.
// - Level-zero current code, 7 bits, serves normal mode and level 1.
// - Further current codes for higher levels at consecutive offsets from 31h.
`timescale 1ns/100ps
module abc_brightness_ctrl #(
  parameter int unsigned BASE_PERIOD = abc_pkg::BASE_PERIOD_CYC,
  parameter int unsigned FAST_PERIOD = abc_pkg::FAST_PERIOD_CYC,
  parameter int unsigned SAMPLE_GAP  = abc_pkg::SAMPLE_GAP_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [3:0] sensorLevel,
  input  wire logic       boostIn,
  input  wire logic [4:0] engineEvent,
  output logic            sensorSwitch,
  output logic            keypadLed1,
  output logic            keypadLed2,
  output logic [6:0]      mainCurrent,
  output logic            irq
);
  import abc_pkg::*;

  // register state
  abc_key_thresh_s   keyThresh;
  abc_sensor_ctrl_s  sensorCtrl;
  logic [7:0]        irqMaskReg;
  logic [NUM_IRQ-1:0] irqFlag;
  logic [6:0]        currentTable [NUM_LEVELS];
  logic [1:0]        keyAuto;
  logic [3:0]        ambientLevel;
  logic              boostActive;
  logic              keyDark;
  logic              keyDark2;
  logic              keyDarkPrev;

  // pin synchronisers
  logic [2:0]        sclSync;
  logic [2:0]        sdaSync;
  logic [2:0]        boostSync;
  logic [3:0]        lvlSync [3];
  logic              sclF;
  logic              sdaF;
  logic [3:0]        levelF;

  // i2c slave state
  abc_i2c_state_e    i2cState;
  logic [3:0]        bitCnt;
  logic [7:0]        shiftReg;
  logic [7:0]        txByte;
  logic [7:0]        regPtr;
  logic              ackOk;
  logic              sclRise;
  logic              sclFall;
  logic              startCond;
  logic              stopCond;
  logic              wrStrobe;
  logic [7:0]        wrAddr;
  logic [7:0]        wrData;

  // sensor state
  abc_sensor_state_e snsState;
  logic [31:0]       timer;
  logic [2:0]        sampleIdx;
  logic [3:0]        firstSample;
  logic              samplesAgree;

  // true when the level code is at or below the threshold setting
  function automatic logic is_dark(input logic [3:0] lvl, input logic [3:0] thr);
    is_dark = (thr != THRESH_INHIBIT) && (lvl <= thr);
  endfunction : is_dark

  // cycles between measurements for a period code
  function automatic logic [31:0] period_cycles(input logic [2:0] code);
    if (code == PERIOD_FAST_CODE) begin
      period_cycles = FAST_PERIOD;
    end else begin
      period_cycles = 32'(BASE_PERIOD) << code;
    end
  endfunction : period_cycles

  // three-stage synchronisers, stage 2 and 3 must agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclSync   <= 3'h7;
      sdaSync   <= 3'h7;
      boostSync <= 3'h0;
      lvlSync   <= '{default: 4'h0};
      sclF      <= 1'b1;
      sdaF      <= 1'b1;
      levelF    <= 4'h0;
    end else begin
      sclSync   <= {sclSync[1:0], sclIn};
      sdaSync   <= {sdaSync[1:0], sdaIn};
      boostSync <= {boostSync[1:0], boostIn};
      lvlSync   <= '{sensorLevel, lvlSync[0], lvlSync[1]};
      if (sclSync[1] == sclSync[2]) sclF <= sclSync[2];
      if (sdaSync[1] == sdaSync[2]) sdaF <= sdaSync[2];
      if (lvlSync[1] == lvlSync[2]) levelF <= lvlSync[2];
    end
  end

  // bus conditions on filtered lines
  assign sclRise   = sclSync[1] == sclSync[2] && sclSync[2] && !sclF;
  assign sclFall   = sclSync[1] == sclSync[2] && !sclSync[2] && sclF;
  assign startCond = sclF && sdaSync[1] == sdaSync[2] && !sdaSync[2] && sdaF;
  assign stopCond  = sclF && sdaSync[1] == sdaSync[2] && sdaSync[2] && !sdaF;

  // read mux; write-only and unmapped offsets read zero
  function automatic logic [7:0] read_reg(input logic [7:0] ofs);
    case (ofs)
      OFS_IRQ_DETECT: read_reg = {2'h0, irqFlag};
      OFS_STATUS:     read_reg = {ambientLevel, 2'h0, keyDark, boostActive};
      default:        read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // i2c slave: address, register pointer, auto-incrementing data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      i2cState <= I2C_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      txByte   <= 8'h00;
      regPtr   <= 8'h00;
      ackOk    <= 1'b0;
      sdaOe    <= 1'b0;
      wrStrobe <= 1'b0;
      wrAddr   <= 8'h00;
      wrData   <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (startCond) begin
        i2cState <= I2C_ADDR;
        bitCnt   <= 4'h0;
        sdaOe    <= 1'b0;
      end else if (stopCond) begin
        i2cState <= I2C_IDLE;
        sdaOe    <= 1'b0;
      end else if (sclRise) begin
        case (i2cState)
          I2C_ADDR, I2C_REG, I2C_WDATA: begin
            shiftReg <= {shiftReg[6:0], sdaF};
            bitCnt   <= bitCnt + 4'h1;
          end
          I2C_RDATA: bitCnt <= bitCnt + 4'h1;
          I2C_ACK_R: ackOk <= !sdaF;
          default: ;
        endcase
      end else if (sclFall) begin
        case (i2cState)
          I2C_ADDR: begin
            if (bitCnt == 4'h8) begin
              if (shiftReg[7:1] == DEV_ADDR) begin
                i2cState <= I2C_ACK_A;
                sdaOe    <= 1'b1;
              end else begin
                i2cState <= I2C_IDLE;
              end
            end
          end
          I2C_ACK_A: begin
            bitCnt <= 4'h0;
            if (shiftReg[0]) begin
              i2cState <= I2C_RDATA;
              txByte   <= read_reg(regPtr);
              sdaOe    <= (read_reg(regPtr) < 8'h80); // pull low for a leading zero
              regPtr   <= regPtr + 8'h01;
            end else begin
              i2cState <= I2C_REG;
              sdaOe    <= 1'b0;
            end
          end
          I2C_REG: begin
            if (bitCnt == 4'h8) begin
              regPtr   <= shiftReg;
              i2cState <= I2C_ACK_REG;
              sdaOe    <= 1'b1;
            end
          end
          I2C_WDATA: begin
            if (bitCnt == 4'h8) begin
              wrStrobe <= 1'b1;
              wrAddr   <= regPtr;
              wrData   <= shiftReg;
              regPtr   <= regPtr + 8'h01;
              i2cState <= I2C_ACK_W;
              sdaOe    <= 1'b1;
            end
          end
          I2C_ACK_REG, I2C_ACK_W: begin
            i2cState <= I2C_WDATA;
            bitCnt   <= 4'h0;
            sdaOe    <= 1'b0;
          end
          I2C_RDATA: begin
            if (bitCnt == 4'h8) begin
              i2cState <= I2C_ACK_R;
              sdaOe    <= 1'b0;
            end else begin
              sdaOe <= !txByte[3'(4'h7 - bitCnt)];
            end
          end
          I2C_ACK_R: begin
            bitCnt <= 4'h0;
            if (ackOk) begin
              i2cState <= I2C_RDATA;
              txByte   <= read_reg(regPtr);
              sdaOe    <= (read_reg(regPtr) < 8'h80); // pull low for a leading zero
              regPtr   <= regPtr + 8'h01;
            end else begin
              i2cState <= I2C_IDLE;
            end
          end
          default: i2cState <= I2C_IDLE;
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) sdaOut <= 1'b0;
    else sdaOut <= 1'b0;
  end

  // control register writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyThresh  <= RST_KEY_THRESH;
      sensorCtrl <= RST_SENSOR_CTRL;
      irqMaskReg <= RST_IRQ_MASK;
      keyAuto    <= RST_KEY_AUTO;
    end else if (wrStrobe) begin
      case (wrAddr)
        OFS_KEY_THRESH:  keyThresh  <= wrData;
        OFS_SENSOR_CTRL: sensorCtrl <= wrData;
        OFS_IRQ_MASK:    irqMaskReg <= {wrData[7], 1'b0, wrData[5:0]};
        OFS_KEY_AUTO:    keyAuto    <= wrData[1:0];
        default: ;
      endcase
    end
  end

  // backlight current table, level 1 at the first offset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      currentTable <= '{default: RST_CURRENT};
    end else if (wrStrobe && wrAddr >= OFS_CURRENT_LVL0 && wrAddr <= OFS_CURRENT_LAST) begin
      currentTable[4'(wrAddr - OFS_CURRENT_LVL0)] <= wrData[6:0];
    end
  end

  // sensor sequencing: power, settle, sample, then wait a period
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      snsState     <= SNS_OFF;
      timer        <= 32'h0000_0000;
      sampleIdx    <= 3'h0;
      firstSample  <= 4'h0;
      samplesAgree <= 1'b0;
      ambientLevel <= 4'h0;
    end else begin
      case (snsState)
        SNS_OFF: begin
          timer <= 32'h0000_0000;
          if (sensorCtrl.sensorPower) snsState <= SNS_MEAS;
        end
        SNS_WAIT: begin
          if (!sensorCtrl.sensorPower) begin
            snsState <= SNS_OFF;
          end else if (timer >= period_cycles(sensorCtrl.samplePeriod)) begin
            snsState <= SNS_MEAS;
            timer    <= 32'h0000_0000;
          end else begin
            timer <= timer + 32'h0000_0001;
          end
        end
        SNS_MEAS: begin
          if (!sensorCtrl.sensorPower) begin
            snsState  <= SNS_OFF;
            sampleIdx <= 3'h0;
          end else if (timer >= 32'(SAMPLE_GAP)) begin
            timer <= 32'h0000_0000;
            if (sampleIdx == 3'h0) begin
              firstSample  <= levelF;
              samplesAgree <= 1'b1;
            end else if (levelF != firstSample) begin
              samplesAgree <= 1'b0;
            end
            if (sampleIdx == {1'b0, sensorCtrl.sampleCount}) begin
              if (sampleIdx == 3'h0 || (samplesAgree && levelF == firstSample)) begin
                ambientLevel <= levelF;
              end
              sampleIdx <= 3'h0;
              snsState  <= SNS_WAIT;
            end else begin
              sampleIdx <= sampleIdx + 3'h1;
            end
          end else begin
            timer <= timer + 32'h0000_0001;
          end
        end
        default: snsState <= SNS_OFF;
      endcase
    end
  end

  // sensor switch: always on in fast mode, else only while measuring
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sensorSwitch <= 1'b0;
    end else begin
      sensorSwitch <= sensorCtrl.switchInvert ^
        (sensorCtrl.sensorPower &&
         (snsState == SNS_MEAS ||
          (snsState == SNS_WAIT && sensorCtrl.samplePeriod == PERIOD_FAST_CODE)));
    end
  end

  // key darkness, key leds, backlight current, boost status
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyDark     <= 1'b0;
      keyDark2    <= 1'b0;
      keyDarkPrev <= 1'b0;
      keypadLed1  <= 1'b0;
      keypadLed2  <= 1'b0;
      mainCurrent <= RST_CURRENT;
      boostActive <= 1'b0;
    end else begin
      keyDark     <= is_dark(ambientLevel, keyThresh.first);
      keyDark2    <= is_dark(ambientLevel, keyThresh.second);
      keyDarkPrev <= keyDark;
      keypadLed1  <= keyAuto[0] && keyDark;
      keypadLed2  <= keyAuto[1] && keyDark2;
      if (sensorCtrl.backlightAuto) begin
        mainCurrent <= currentTable[ambientLevel];
      end else begin
        mainCurrent <= currentTable[0];
      end
      if (boostSync[1] == boostSync[2]) boostActive <= boostSync[2];
    end
  end

  // sticky detect flags; held clear while the clear bit is set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqFlag <= '0;
    end else if (irqMaskReg[IRQ_CLEAR_BIT]) begin
      irqFlag <= '0;
    end else begin
      irqFlag <= irqFlag | {engineEvent, keyDark != keyDarkPrev};
    end
  end

  // interrupt output from unmasked flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqFlag & ~irqMaskReg[NUM_IRQ-1:0]);
    end
  end

endmodule : abc_brightness_ctrl
